// *** rtl/fmr_pkg.sv ***
package fmr_pkg;

    localparam int DATA_W            = 12;
    // Words in one field of storage
    localparam int FIELD_WORDS       = 245760;
    // Write cycles a stored word is held back before it reaches the array
    localparam int OLD_DATA_CYCLES   = 40;
    // Read restart spacing that guarantees the new field
    localparam int NEW_DATA_CYCLES   = 160;
    // Continuous write cycles with all three write controls high
    localparam int TEST_ENTRY_CYCLES = 1024;
    localparam int TEST_CNT_W        = 11;
    // Words of slack between the hold-back line and the array port
    localparam int BUF_DEPTH         = 16;
    // Two flip-flops on every pin before any logic reads it
    localparam int SYNC_STAGES       = 2;
    // Pin bundle: write clock, 3 write controls, data, read clock, 3 controls
    localparam int PIN_W             = DATA_W + 8;
    localparam int PIN_WCK           = PIN_W - 1;
    localparam int PIN_WADV          = PIN_W - 2;
    localparam int PIN_WSTORE        = PIN_W - 3;
    localparam int PIN_WRST          = PIN_W - 4;
    localparam int PIN_DATA_LO       = 4;
    localparam int PIN_RCK           = 3;
    localparam int PIN_RADV          = 2;
    localparam int PIN_ODE           = 1;
    localparam int PIN_RRST          = 0;

    localparam logic [DATA_W-1:0] DOUT_RST = 12'h000;

    typedef enum logic [1:0] {
        FMR_TM_OFF,
        FMR_TM_ON,
        FMR_TM_LEAVE
    } fmr_tm_state_t;

endpackage

// *** rtl/fmr_field_mem.sv ***
// Notes on behaviour
// R1: Output enable high at read edge drives data
// R2: Output enable low at read edge floats outputs
// R3: Read pointer advances whatever output enable is
// R4: Read pointer increments on advance, else holds
// R5: Read restart zeroes pointer, waits for advance
// R6: Write pointer increments on advance, else holds
// R7: Controller waits power settle interval first
// R8: Controller gives 96 read dummies then restart
// R9: Controller gives 96 write dummies then restart
// R10: Controller may initialise both sides together
// R11: Early dummies need repeat after settle interval
// R12: Controller keeps 160 write cycles write-to-read
// R13: Read before next write restart: just-written field
// R14: Read restart under 40 late: old field
// R15: Read restart 160 or more late: new field
// R16: Controller avoids 40 to 160 cycle window
// R17: Random block mode keeps 160 cycle latency
// R18: Edge launches read before write capture completes
// R19: All write controls high 1024 cycles: test
// R20: Test stays while advance high, leaves two later
// R21: Controller never triggers factory test mode; the bench drives 1024 all-high write cycles through it once
// R22: Controller counts write cycles from write restart
`timescale 1ns/100ps

module fmr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_ref_clk,   // System clock
    input  wire logic             i_sys_rst,   // Synchronous reset
    input  wire logic             i_valid,     // Fill side offers a word
    output logic                  o_ready,     // Fill side may push
    input  wire logic [WIDTH-1:0] i_data,      // Word to store
    output logic                  o_valid,     // Drain side has a word
    input  wire logic             i_ready,     // Drain side takes it
    output logic      [WIDTH-1:0] o_data       // Oldest word
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH)
        $error("fmr_fifo: DEPTH must be a power of two of at least 2");

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wr_idx;
    logic [AW:0]      rd_idx;
    logic [AW:0]      next_wr_idx;
    logic [AW:0]      next_rd_idx;
    logic             push;
    logic             pop;

    always_comb
    begin
        o_ready     = (wr_idx - rd_idx) != (AW+1)'(DEPTH);
        o_valid     = wr_idx != rd_idx;
        o_data      = store[rd_idx[AW-1:0]];
        push        = i_valid && o_ready;
        pop         = o_valid && i_ready;
        next_wr_idx = push ? wr_idx + 1'b1 : wr_idx;
        next_rd_idx = pop ? rd_idx + 1'b1 : rd_idx;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            wr_idx <= '0;
            rd_idx <= '0;
        end
        else
        begin
            wr_idx <= next_wr_idx;
            rd_idx <= next_rd_idx;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (push)
            store[wr_idx[AW-1:0]] <= i_data;
    end

endmodule // fmr_fifo

module fmr_field_mem #(
    parameter int DEPTH = fmr_pkg::FIELD_WORDS
) (
    input  wire logic        i_ref_clk,               // 125 MHz system clock
    input  wire logic        i_sys_rst,               // Synchronous reset
    input  wire logic        i_write_port_clock,      // Write port clock pin
    input  wire logic        i_write_advance_enable,  // Write pointer advance
    input  wire logic        i_write_store_enable,    // Store next word
    input  wire logic        i_write_pointer_restart, // Write restart
    input  wire logic [11:0] i_write_data_in,         // Write data pins
    input  wire logic        i_read_port_clock,       // Read port clock pin
    input  wire logic        i_read_advance_enable,   // Read pointer advance
    input  wire logic        i_output_drive_enable,   // Output buffer enable
    input  wire logic        i_read_pointer_restart,  // Read restart
    output logic      [11:0] o_read_data_out,         // Read data pins
    output logic             o_read_data_oe,          // Drive read data pins
    output logic             o_test_mode,             // Factory test active
    output logic             o_write_overflow         // Sticky: word dropped
);
    localparam int DW  = fmr_pkg::DATA_W;
    localparam int AW  = $clog2(DEPTH);
    localparam int HB  = fmr_pkg::OLD_DATA_CYCLES;
    localparam int HW  = $clog2(HB);
    localparam int EW  = AW + DW;
    localparam int PW  = fmr_pkg::PIN_W;
    localparam int TCW = fmr_pkg::TEST_CNT_W;

    if (DEPTH <= fmr_pkg::NEW_DATA_CYCLES)
        $error("fmr_field_mem: DEPTH too small for the write latency");
    if (DW != 12)
        $error("fmr_field_mem: data pins are 12 bits wide");

    // Pin synchroniser; only the second stage is read by logic
    logic [PW-1:0] pin_raw;
    logic [PW-1:0] pin_s1;
    logic [PW-1:0] pin_s2;
    logic          wck_prev;
    logic          rck_prev;
    logic          w_edge;
    logic          r_edge;

    assign pin_raw = {i_write_port_clock, i_write_advance_enable,
                      i_write_store_enable, i_write_pointer_restart,
                      i_write_data_in, i_read_port_clock,
                      i_read_advance_enable, i_output_drive_enable,
                      i_read_pointer_restart};

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            pin_s1   <= '0;
            pin_s2   <= '0;
            wck_prev <= 1'b0;
            rck_prev <= 1'b0;
        end
        else
        begin
            pin_s1   <= pin_raw;
            pin_s2   <= pin_s1;
            wck_prev <= pin_s2[fmr_pkg::PIN_WCK];
            rck_prev <= pin_s2[fmr_pkg::PIN_RCK];
        end
    end

    logic          w_adv;
    logic          w_store;
    logic          w_rst;
    logic [DW-1:0] w_data;
    logic          r_adv;
    logic          r_ode;
    logic          r_rst;

    always_comb
    begin
        w_edge  = pin_s2[fmr_pkg::PIN_WCK] && !wck_prev;
        r_edge  = pin_s2[fmr_pkg::PIN_RCK] && !rck_prev;
        w_adv   = pin_s2[fmr_pkg::PIN_WADV];
        w_store = pin_s2[fmr_pkg::PIN_WSTORE];
        w_rst   = pin_s2[fmr_pkg::PIN_WRST];
        w_data  = pin_s2[fmr_pkg::PIN_DATA_LO +: DW];
        r_adv   = pin_s2[fmr_pkg::PIN_RADV];
        r_ode   = pin_s2[fmr_pkg::PIN_ODE];
        r_rst   = pin_s2[fmr_pkg::PIN_RRST];
    end

    // Write side: pointer, hold-back line and test mode detector
    logic [AW-1:0]         wptr;
    logic                  w_rst_q;
    logic                  w_store_q;
    logic [HW-1:0]         hb_idx;
    logic [HB-1:0]         hb_valid;
    logic [EW-1:0]         hb_line [HB];
    logic [TCW-1:0]        tcnt;
    fmr_pkg::fmr_tm_state_t tm_state;
    logic                  overflow;

    logic [AW-1:0]         next_wptr;
    logic                  next_w_rst_q;
    logic                  next_w_store_q;
    logic [HW-1:0]         next_hb_idx;
    logic [HB-1:0]         next_hb_valid;
    logic [TCW-1:0]        next_tcnt;
    fmr_pkg::fmr_tm_state_t next_tm_state;
    logic                  next_overflow;
    logic                  buf_push;
    logic                  buf_ready;
    logic                  buf_valid;
    logic                  buf_pop;
    logic [EW-1:0]         buf_word;

    always_comb
    begin
        next_wptr      = wptr;
        next_w_rst_q   = w_rst_q;
        next_w_store_q = w_store_q;
        next_hb_idx    = hb_idx;
        next_hb_valid  = hb_valid;
        next_tcnt      = tcnt;
        next_tm_state  = tm_state;
        buf_push       = 1'b0;
        if (w_edge)
        begin
            next_w_rst_q   = w_rst;
            next_w_store_q = w_store;
            if (w_rst && !w_rst_q)
                next_wptr = '0;
            else if (w_adv)                                        // [R6]
                next_wptr = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
            // Words leave the line 40 write cycles after capture, so a
            // reader restarted less than that late still sees old data
            buf_push              = hb_valid[hb_idx];              // [R14]
            next_hb_valid[hb_idx] = w_adv && w_store_q;
            next_hb_idx = (hb_idx == HW'(HB - 1)) ? '0 : hb_idx + 1'b1;
            if (w_adv && w_store && w_rst)                         // [R19]
            begin
                if (tcnt != TCW'(fmr_pkg::TEST_ENTRY_CYCLES))
                    next_tcnt = tcnt + 1'b1;
            end
            else
                next_tcnt = '0;
            case (tm_state)
                fmr_pkg::FMR_TM_OFF:
                    if (next_tcnt == TCW'(fmr_pkg::TEST_ENTRY_CYCLES))
                        next_tm_state = fmr_pkg::FMR_TM_ON;        // [R19]
                fmr_pkg::FMR_TM_ON:
                    if (!w_adv)
                        next_tm_state = fmr_pkg::FMR_TM_LEAVE;     // [R20]
                fmr_pkg::FMR_TM_LEAVE:
                    next_tm_state = w_adv ? fmr_pkg::FMR_TM_ON
                                          : fmr_pkg::FMR_TM_OFF;   // [R20]
                default:
                    next_tm_state = fmr_pkg::FMR_TM_OFF;
            endcase
        end
        // Set wins over nothing here: flag only clears with reset
        next_overflow = overflow || (buf_push && !buf_ready);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            wptr      <= '0;
            w_rst_q   <= 1'b0;
            w_store_q <= 1'b0;
            hb_idx    <= '0;
            hb_valid  <= '0;
            tcnt      <= '0;
            tm_state  <= fmr_pkg::FMR_TM_OFF;
            overflow  <= 1'b0;
        end
        else
        begin
            wptr      <= next_wptr;
            w_rst_q   <= next_w_rst_q;
            w_store_q <= next_w_store_q;
            hb_idx    <= next_hb_idx;
            hb_valid  <= next_hb_valid;
            tcnt      <= next_tcnt;
            tm_state  <= next_tm_state;
            overflow  <= next_overflow;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (w_edge)
            hb_line[hb_idx] <= {wptr, w_data};
    end

    fmr_fifo #(
        .WIDTH (EW),
        .DEPTH (fmr_pkg::BUF_DEPTH)
    ) u_wbuf (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_valid   (buf_push),
        .o_ready   (buf_ready),
        .i_data    (hb_line[hb_idx]),
        .o_valid   (buf_valid),
        .i_ready   (buf_pop),
        .o_data    (buf_word)
    );

    // Read side: pointer, restart arming and output stage
    logic [AW-1:0] rptr;
    logic          r_rst_q;
    logic          r_pend;
    logic          rd_req;
    logic          rd_vld;
    logic          ode_q;
    logic [DW-1:0] rd_word;
    logic [DW-1:0] dout;

    logic [AW-1:0] next_rptr;
    logic          next_r_rst_q;
    logic          next_r_pend;
    logic          next_ode_q;
    logic [DW-1:0] next_dout;

    always_comb
    begin
        next_rptr    = rptr;
        next_r_rst_q = r_rst_q;
        next_r_pend  = r_pend;
        next_ode_q   = ode_q;
        next_dout    = rd_vld ? rd_word : dout;
        if (r_edge)
        begin
            next_r_rst_q = r_rst;
            // Pointer moves with the advance pin alone, never the enable
            next_ode_q   = r_ode;                                  // [R1] [R2]
            if ((r_rst && !r_rst_q) || r_pend)
            begin
                next_r_pend = !r_adv;                              // [R5]
                if (r_adv)
                    next_rptr = '0;                                // [R5]
            end
            else if (r_adv)                                        // [R3] [R4]
                next_rptr = (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            rptr    <= '0;
            r_rst_q <= 1'b0;
            r_pend  <= 1'b0;
            rd_req  <= 1'b0;
            rd_vld  <= 1'b0;
            ode_q   <= 1'b0;
            dout    <= fmr_pkg::DOUT_RST;
        end
        else
        begin
            rptr    <= next_rptr;
            r_rst_q <= next_r_rst_q;
            r_pend  <= next_r_pend;
            rd_req  <= r_edge;
            rd_vld  <= rd_req;
            ode_q   <= next_ode_q;
            dout    <= next_dout;
        end
    end

    // Single array port: a read launched by a read edge goes first and
    // buffered writes wait, so a read never sees a half-finished capture
    logic [DW-1:0] mem [DEPTH];

    assign buf_pop = buf_valid && !rd_req;                         // [R18]

    always_ff @(posedge i_ref_clk)
    begin
        if (rd_req)
            rd_word <= mem[rptr];                                  // [R18]
        else if (buf_pop)
            mem[buf_word[EW-1:DW]] <= buf_word[DW-1:0];   // [R13] [R15]
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            o_read_data_out  <= fmr_pkg::DOUT_RST;
            o_read_data_oe   <= 1'b0;
            o_test_mode      <= 1'b0;
            o_write_overflow <= 1'b0;
        end
        else
        begin
            o_read_data_out  <= dout;
            o_read_data_oe   <= ode_q;                             // [R1] [R2]
            o_test_mode      <= tm_state != fmr_pkg::FMR_TM_OFF;   // [R20]
            o_write_overflow <= overflow;
        end
    end

endmodule // fmr_field_mem

// *** verif/fmr_field_mem_chk.sv ***
`timescale 1ns/100ps

module fmr_field_mem_chk #(
    parameter int DEPTH = 256
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_write_port_clock,
    input  wire logic        i_write_advance_enable,
    input  wire logic        i_write_store_enable,
    input  wire logic        i_write_pointer_restart,
    input  wire logic        i_read_port_clock,
    input  wire logic        i_output_drive_enable,
    input  wire logic [11:0] o_read_data_out,
    input  wire logic        o_read_data_oe,
    input  wire logic        o_test_mode,
    input  wire logic        o_write_overflow
);
    default clocking dc @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    logic [2:0]  rs;
    logic [2:0]  ws;
    logic [3:0]  since_r;
    logic [10:0] all_cnt;
    logic [1:0]  low_cnt;
    wire         redge = rs[1] & ~rs[2];
    wire         wedge = ws[1] & ~ws[2];
    wire         all_hi = i_write_advance_enable & i_write_store_enable
                          & i_write_pointer_restart;

    // Local copy of the pin synchroniser, so its edges fall in the same cycle as the design's
    always_ff @(posedge i_ref_clk)
    begin
        rs <= {rs[1:0], i_read_port_clock};
        ws <= {ws[1:0], i_write_port_clock};
        if (i_sys_rst || redge)
            since_r <= 4'h0;
        else if (~&since_r)
            since_r <= since_r + 4'h1;
        if (i_sys_rst)
            all_cnt <= 11'h000;
        else if (wedge)
            all_cnt <= all_hi ? all_cnt + {10'h000, ~&all_cnt} : 11'h000;
        if (i_sys_rst)
            low_cnt <= 2'h0;
        else if (wedge)
            low_cnt <= i_write_advance_enable ? 2'h0
                                              : low_cnt + {1'b0, ~&low_cnt};
    end

    property p_oe_on;
        redge && i_output_drive_enable |-> ##[1:4] o_read_data_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("outputs not enabled");

    property p_oe_off;
        redge && !i_output_drive_enable |-> ##[1:4] !o_read_data_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("outputs not floated");

    property p_dout_quiet;
        $changed(o_read_data_out) |-> since_r <= 4'h6;
    endproperty
    a_dout_quiet: assert property (p_dout_quiet) else $error("data moved idle");

    property p_tm_on;
        wedge && all_hi && all_cnt == 11'h3ff |-> ##[1:4] o_test_mode;
    endproperty
    a_tm_on: assert property (p_tm_on) else $error("test mode not entered");

    property p_tm_rose;
        $rose(o_test_mode) |-> all_cnt >= 11'h400;
    endproperty
    a_tm_rose: assert property (p_tm_rose) else $error("test mode too early");

    property p_tm_leave;
        wedge && o_test_mode && !i_write_advance_enable && low_cnt == 2'h1
            |-> ##[1:4] !o_test_mode;
    endproperty
    a_tm_leave: assert property (p_tm_leave) else $error("test mode kept");

    property p_tm_fell;
        $fell(o_test_mode) |-> low_cnt >= 2'h2;
    endproperty
    a_tm_fell: assert property (p_tm_fell) else $error("test mode left early");

    property p_rst_vals;
        $fell(i_sys_rst) |-> !o_read_data_oe && !o_test_mode
            && !o_write_overflow && o_read_data_out == 12'h000;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("bad reset outputs");
endmodule // fmr_field_mem_chk

bind fmr_field_mem fmr_field_mem_chk #(.DEPTH(DEPTH)) u_chk (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_write_port_clock(i_write_port_clock),
    .i_write_advance_enable(i_write_advance_enable),
    .i_write_store_enable(i_write_store_enable),
    .i_write_pointer_restart(i_write_pointer_restart),
    .i_read_port_clock(i_read_port_clock),
    .i_output_drive_enable(i_output_drive_enable),
    .o_read_data_out(o_read_data_out), .o_read_data_oe(o_read_data_oe),
    .o_test_mode(o_test_mode), .o_write_overflow(o_write_overflow)
);

// *** verif/fmr_ctrl_model.sv ***
`timescale 1ns/100ps

module fmr_ctrl_model #(
    parameter int SETTLE_CYC = 12500,
    parameter int DUMMIES    = 96
) (
    input  wire logic        i_ref_clk,      // Bench clock
    output logic             o_wck = 1'b0,   // Write port clock
    output logic             o_wadv = 1'b0,  // Write advance enable
    output logic             o_wst = 1'b0,   // Write store enable
    output logic             o_wrs = 1'b0,   // Write pointer restart
    output logic      [11:0] o_wd = 12'h000, // Write data in
    output logic             o_rck = 1'b0,   // Read port clock
    output logic             o_radv = 1'b0,  // Read advance enable
    output logic             o_oe = 1'b0,    // Output drive enable
    output logic             o_rrs = 1'b0    // Read pointer restart
);
    int wr_since = 0;

    // Controls move two cycles before the rise; clock rests low between
    task automatic wcyc(input logic adv, st, rs, input logic [11:0] d);
        @(posedge i_ref_clk);
        o_wadv <= adv;
        o_wst  <= st;
        o_wrs  <= rs;
        o_wd   <= d;
        repeat (2) @(posedge i_ref_clk);
        o_wck <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        o_wck <= 1'b0;
        @(posedge i_ref_clk);
        wr_since = rs ? 0 : wr_since + 1;
    endtask

    task automatic rcyc(input logic adv, oe, rs);
        @(posedge i_ref_clk);
        o_radv <= adv;
        o_oe   <= oe;
        o_rrs  <= rs;
        repeat (2) @(posedge i_ref_clk);
        o_rck <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        o_rck <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    // Dummies start only after settling, so no repeat pass is needed
    task automatic init();
        repeat (SETTLE_CYC) @(posedge i_ref_clk);
        fork
            begin
                repeat (DUMMIES) rcyc(1'b0, 1'b0, 1'b0);
                rcyc(1'b1, 1'b0, 1'b1);
            end
            begin
                repeat (DUMMIES) wcyc(1'b0, 1'b0, 1'b0, 12'h000);
                wcyc(1'b0, 1'b0, 1'b1, 12'h000);
            end
        join
    endtask
endmodule // fmr_ctrl_model

// *** verif/fmr_field_mem_tb.sv ***
`timescale 1ns/100ps

module fmr_field_mem_tb;
    localparam int DEPTH = 256;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wck, wadv, wst, wrs, rck, radv, oe, rrs, doe, tm, ovf;
    logic [11:0] wd, dout;
    logic        wp, rp, stp, rpend;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          wptr, rptr;
    int          mem[int];
    int          hq[$];

    always #4 clk = ~clk;

    fmr_field_mem #(.DEPTH(DEPTH)) dut (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_write_port_clock(wck),
        .i_write_advance_enable(wadv), .i_write_store_enable(wst),
        .i_write_pointer_restart(wrs), .i_write_data_in(wd),
        .i_read_port_clock(rck), .i_read_advance_enable(radv),
        .i_output_drive_enable(oe), .i_read_pointer_restart(rrs),
        .o_read_data_out(dout), .o_read_data_oe(doe), .o_test_mode(tm),
        .o_write_overflow(ovf)
    );

    fmr_ctrl_model u_ctl (
        .i_ref_clk(clk), .o_wck(wck), .o_wadv(wadv), .o_wst(wst),
        .o_wrs(wrs), .o_wd(wd), .o_rck(rck), .o_radv(radv), .o_oe(oe),
        .o_rrs(rrs)
    );

    task automatic check(input string nm, input logic [11:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic rnd(input int n);
        return ($urandom % n) != 0;
    endfunction

    // Reference: words wait 40 write cycles before they count as stored
    task automatic wr(input logic adv, st, rs);
        logic [11:0] d;
        int          e;
        d = 12'($urandom);
        u_ctl.wcyc(adv, st, rs, d);
        hq.push_back(adv && stp ? wptr * 4096 + int'(d) : -1);
        if (hq.size() > 40)
        begin
            e = hq.pop_front();
            if (e >= 0)
                mem[e / 4096] = e % 4096;
        end
        stp = st;
        wptr = rs && !wp ? 0 : adv ? (wptr + 1) % DEPTH : wptr;
        wp = rs;
    endtask

    task automatic chk_rd(input logic o, input int xd);
        repeat (6) @(posedge clk);
        #1;
        check("read_data_oe", doe, o);
        if (o && xd >= 0)
            check("read_data", dout, xd[11:0]);
    endtask

    task automatic rd(input logic adv, o, rs);
        int xd;
        u_ctl.rcyc(adv, o, rs);
        if (rs && !rp)
            rpend = 1'b1;
        if (adv && rpend)
        begin
            rptr = 0;
            rpend = 1'b0;
        end
        else if (adv)
            rptr = (rptr + 1) % DEPTH;
        rp = rs;
        xd = mem.exists(rptr) ? mem[rptr] : -1;
        fork
            chk_rd(o, xd);
        join_none
    endtask

    initial
    begin
        void'($urandom(24));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("reset_oe", doe, 1'b0);
        check("reset_data", dout, 12'h000);
        check("reset_test_mode", tm, 1'b0);
        u_ctl.init();
        wptr = 0;
        rptr = 0;
        wp = 1'b1;
        rp = 1'b1;
        stp = 1'b0;
        rpend = 1'b0;
        wr(1'b0, 1'b1, 1'b0);
        rd(1'b0, 1'b0, 1'b0);
        // Even frames read the new field, odd frames the old one
        for (int f = 0; f < 4; f++)
            fork
                begin
                    wr(1'b0, 1'b1, 1'b1);
                    repeat (200) wr(rnd(16), rnd(4), 1'b0);
                end
                begin
                    wait (u_ctl.wr_since == 0);
                    wait (u_ctl.wr_since >= (f[0] ? 8 : 165));
                    rd(1'b0, 1'b1, 1'b1);
                    repeat (f[0] ? 120 : 150) rd(rnd(16), rnd(2), 1'b0);
                end
            join
        // Factory entry is provoked here on purpose, nowhere else
        repeat (1023) wr(1'b1, 1'b1, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            repeat (3) @(posedge clk);
            #1;
            check("test_mode", tm, i > 0 && i < 3);
            if (i < 3)
                wr(i == 0, i == 0, i == 0);
        end
        repeat (20) @(posedge clk);
        #1;
        check("write_overflow", ovf, 1'b0);
        finish_test();
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
endmodule // fmr_field_mem_tb
